//--- rtl/irs_pkg.sv
// Purpose: Constants and types for the interrupt request and stacking block
// Assumes: 8-bit core, 16-bit addresses, 32 vector slots
// Notes:   Vector n sits at VEC_TOP - 2n, high byte first
package irs_pkg;
  localparam int          NVEC      = 32;
  localparam logic [15:0] VEC_TOP   = 16'hfffe;
  localparam logic [31:0] IMPL_MASK = 32'h009f_f0ec;
  localparam int          PIN_VEC   = 2;
  localparam int          MASK_BIT  = 3;
  localparam logic [2:0]  PUSH_LAST = 3'h4;
  localparam logic [2:0]  POP_LAST  = 3'h5;
  localparam logic [2:0]  FILL_LAST = 3'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH = 3'b001,
    ST_VECH = 3'b011,
    ST_VECL = 3'b010,
    ST_FILL = 3'b110,
    ST_POP  = 3'b111
  } irs_state_e;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  x;
    logic [7:0]  a;
    logic [7:0]  cond;
  } irs_regs_s;

  typedef struct packed {
    logic en;
    logic mode;
    logic ie;
    logic pud;
  } irs_pin_cfg_s;
endpackage

//--- rtl/irs_top.sv
// Purpose: Pin request detect, flag gating, vector select, stack frame engine
// Assumes: Memory answers i_mem_rdata in the same cycle o_mem_re is high
// Notes:   Pin is active low; vector 0 and 1 are outside this block
//
// What this block does
// - After pushing, stack pointer is one below the stored condition codes.
// - Pushed program counter is the next main-program instruction address.
// - Index high byte is never pushed or restored.
// - Return pops saved registers in reverse push order.
// - Return then fetches three program bytes from restored counter.
// - A flag cleared early sets again on a new event.
// - Pin detects requests only while its enable bit is 1.
// - Synchronous sampling detects edges, or edges plus levels, per mode bit.
// - In stop mode an asynchronous path lets the enabled pin wake.
// - Pin event always sets flag; request only when its enable is set.
// - Pullup on while enabled and disable bit 0; off when 1.
// - Pin level is visible to branch-on-pin instructions when enabled.
// - Pin flag sets on deasserted to asserted transition.
// - Level mode holds flag set while pin stays asserted.
// - Vector is two bytes, high byte at lower address.
// - Flag sets on condition; request only with local enable 1.
// - Unmasked entry pushes counter low, counter high, X, A, codes, sets mask, fetches vector.
// - Priority rises with vector address.
// - Slots 31 to 24, 22, 21, 11 to 8 and 4 unused; others serve named sources.
`timescale 1ns/1ps
module irs_top (
  // Clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset,
  // Request pin and its controls
  input  wire logic                 i_irq_pin_n,
  input  wire irs_pkg::irs_pin_cfg_s i_pin_cfg,
  input  wire logic                 i_stop,
  output logic                      o_pullup_on,
  output logic                      o_pin_level,
  output logic                      o_stop_wake,
  // Source flags
  input  wire logic [31:0]          i_src_event,
  input  wire logic [31:0]          i_src_ie,
  input  wire logic [31:0]          i_src_ack,
  output logic [31:0]               o_flags,
  output logic                      o_irq_request,
  output logic [15:0]               o_vector_addr,
  // Core side
  input  wire logic                 i_insn_done,
  input  wire logic                 i_return_start,
  input  wire irs_pkg::irs_regs_s   i_regs,
  input  wire logic [15:0]          i_sp,
  output irs_pkg::irs_regs_s        o_regs,
  output logic [15:0]               o_sp,
  output logic [23:0]               o_queue,
  output logic                      o_mask_set,
  output logic                      o_done,
  output logic                      o_busy,
  // Memory port
  input  wire logic [7:0]           i_mem_rdata,
  output logic [15:0]               o_mem_addr,
  output logic [7:0]                o_mem_wdata,
  output logic                      o_mem_we,
  output logic                      o_mem_re
);

  // ************************************************
  // Functions
  // ************************************************
  function automatic logic [15:0] win_vec(input logic [31:0] p);
    logic [15:0] v;
    v = irs_pkg::VEC_TOP;
    for (int i = irs_pkg::NVEC - 1; i >= 0; i--) begin
      if (p[i]) begin
        v = irs_pkg::VEC_TOP - 16'(2 * i);
      end
    end
    return v;
  endfunction

  function automatic logic [7:0] frame_byte(input irs_pkg::irs_regs_s r, input logic [2:0] k);
    logic [7:0] b;
    unique case (k)
      3'h0:    b = r.pc[7:0];
      3'h1:    b = r.pc[15:8];
      3'h2:    b = r.x;
      3'h3:    b = r.a;
      default: b = r.cond;
    endcase
    return b;
  endfunction

  // ************************************************
  // Pin detect and flags
  // ************************************************
  logic        s1_q, s2_q, prev_q, prev_d;
  logic        pull_q, pull_d, lvl_q, lvl_d, wake_q, wake_d, wake_set;
  logic [31:0] flags_q, flags_d, ev, ie, pend;
  logic        req_q, req_d;
  logic        pin_ev;

  always_comb begin
    pin_ev   = i_pin_cfg.en & ((prev_q & ~s2_q) | (i_pin_cfg.mode & ~s2_q));
    ev       = i_src_event;
    ev[irs_pkg::PIN_VEC] = pin_ev;
    ie       = i_src_ie;
    ie[irs_pkg::PIN_VEC] = i_pin_cfg.ie;
    flags_d  = ((flags_q & ~i_src_ack) | ev) & irs_pkg::IMPL_MASK;
    flags_d[irs_pkg::PIN_VEC] = flags_d[irs_pkg::PIN_VEC] & i_pin_cfg.en;
    pend     = flags_q & ie & irs_pkg::IMPL_MASK;
    req_d    = |pend;
    prev_d   = s2_q;
    pull_d   = i_pin_cfg.en & ~i_pin_cfg.pud;
    lvl_d    = i_pin_cfg.en ? s2_q : 1'b1;
    wake_d   = wake_q & i_stop;
    wake_set = i_stop & i_pin_cfg.en & ~i_irq_pin_n;
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      prev_q  <= 1'b1;
      flags_q <= 32'h0000_0000;
      req_q   <= 1'b0;
      pull_q  <= 1'b0;
      lvl_q   <= 1'b1;
    end else begin
      s1_q    <= i_irq_pin_n;
      s2_q    <= s1_q;
      prev_q  <= prev_d;
      flags_q <= flags_d;
      req_q   <= req_d;
      pull_q  <= pull_d;
      lvl_q   <= lvl_d;
    end
  end

  // Wake flop set straight from the pin while clocks are halted
  always_ff @(posedge i_mclk or posedge i_reset or posedge wake_set) begin
    if (i_reset) begin
      wake_q <= 1'b0;
    end else if (wake_set) begin
      wake_q <= 1'b1;
    end else begin
      wake_q <= wake_d;
    end
  end

  // ************************************************
  // Stack frame engine
  // ************************************************
  irs_pkg::irs_state_e st_q, st_d;
  irs_pkg::irs_regs_s  regs_q, regs_d;
  logic [2:0]  idx_q, idx_d;
  logic [15:0] sp_q, sp_d, addr_q, addr_d, vec_q, vec_d;
  logic [23:0] q_q, q_d;
  logic [7:0]  wd_q, wd_d;
  logic        we_q, we_d, re_q, re_d, ms_q, ms_d, done_q, done_d;
  logic        fv_q, fv_d, busy_q, busy_d, start;

  always_comb begin
    st_d   = st_q;
    regs_d = regs_q;
    idx_d  = idx_q;
    sp_d   = sp_q;
    addr_d = addr_q;
    vec_d  = vec_q;
    q_d    = q_q;
    fv_d   = fv_q;
    wd_d   = 8'h00;
    we_d   = 1'b0;
    re_d   = 1'b0;
    ms_d   = 1'b0;
    done_d = 1'b0;
    start  = i_insn_done & ~i_regs.cond[irs_pkg::MASK_BIT] & req_q;
    unique case (st_q)
      irs_pkg::ST_IDLE: begin
        if (start) begin
          st_d   = irs_pkg::ST_PUSH;
          idx_d  = 3'h0;
          sp_d   = i_sp;
          regs_d = i_regs;
          vec_d  = win_vec(pend);
        end else if (i_return_start) begin
          st_d  = irs_pkg::ST_POP;
          idx_d = 3'h0;
          sp_d  = i_sp;
        end
      end
      irs_pkg::ST_PUSH: begin
        we_d   = 1'b1;
        addr_d = sp_q;
        wd_d   = frame_byte(regs_q, idx_q);
        sp_d   = sp_q - 16'h0001;
        idx_d  = idx_q + 3'h1;
        if (idx_q == irs_pkg::PUSH_LAST) begin
          st_d = irs_pkg::ST_VECH;
        end
      end
      irs_pkg::ST_VECH: begin
        ms_d   = 1'b1;
        regs_d.cond[irs_pkg::MASK_BIT] = 1'b1;
        re_d   = 1'b1;
        addr_d = vec_q;
        st_d   = irs_pkg::ST_VECL;
      end
      irs_pkg::ST_VECL: begin
        re_d   = 1'b1;
        addr_d = vec_q + 16'h0001;
        regs_d.pc[15:8] = i_mem_rdata;
        fv_d   = 1'b1;
        idx_d  = 3'h0;
        st_d   = irs_pkg::ST_FILL;
      end
      irs_pkg::ST_FILL: begin
        idx_d = idx_q + 3'h1;
        if (idx_q == 3'h0) begin
          if (fv_q) begin
            regs_d.pc[7:0] = i_mem_rdata;
            addr_d = {regs_q.pc[15:8], i_mem_rdata};
          end else begin
            addr_d = regs_q.pc;
          end
        end else begin
          q_d    = {q_q[15:0], i_mem_rdata};
          addr_d = addr_q + 16'h0001;
        end
        re_d = (idx_q != irs_pkg::FILL_LAST);
        if (idx_q == irs_pkg::FILL_LAST) begin
          st_d   = irs_pkg::ST_IDLE;
          done_d = 1'b1;
        end
      end
      irs_pkg::ST_POP: begin
        idx_d = idx_q + 3'h1;
        if (idx_q != irs_pkg::POP_LAST) begin
          re_d   = 1'b1;
          sp_d   = sp_q + 16'h0001;
          addr_d = sp_q + 16'h0001;
        end
        unique case (idx_q)
          3'h1:    regs_d.cond = i_mem_rdata;
          3'h2:    regs_d.a = i_mem_rdata;
          3'h3:    regs_d.x = i_mem_rdata;
          3'h4:    regs_d.pc[15:8] = i_mem_rdata;
          3'h5:    regs_d.pc[7:0] = i_mem_rdata;
          default: regs_d = regs_q;
        endcase
        if (idx_q == irs_pkg::POP_LAST) begin
          fv_d  = 1'b0;
          idx_d = 3'h0;
          st_d  = irs_pkg::ST_FILL;
        end
      end
      default: st_d = irs_pkg::ST_IDLE;
    endcase
    busy_d = (st_d != irs_pkg::ST_IDLE);
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      st_q   <= irs_pkg::ST_IDLE;
      regs_q <= '0;
      idx_q  <= 3'h0;
      sp_q   <= 16'h0000;
      addr_q <= 16'h0000;
      vec_q  <= 16'h0000;
      q_q    <= 24'h00_0000;
      wd_q   <= 8'h00;
      we_q   <= 1'b0;
      re_q   <= 1'b0;
      ms_q   <= 1'b0;
      done_q <= 1'b0;
      fv_q   <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      regs_q <= regs_d;
      idx_q  <= idx_d;
      sp_q   <= sp_d;
      addr_q <= addr_d;
      vec_q  <= vec_d;
      q_q    <= q_d;
      wd_q   <= wd_d;
      we_q   <= we_d;
      re_q   <= re_d;
      ms_q   <= ms_d;
      done_q <= done_d;
      fv_q   <= fv_d;
      busy_q <= busy_d;
    end
  end

  assign o_pullup_on   = pull_q;
  assign o_pin_level   = lvl_q;
  assign o_stop_wake   = wake_q;
  assign o_flags       = flags_q;
  assign o_irq_request = req_q;
  assign o_vector_addr = vec_q;
  assign o_regs        = regs_q;
  assign o_sp          = sp_q;
  assign o_queue       = q_q;
  assign o_mask_set    = ms_q;
  assign o_done        = done_q;
  assign o_busy        = busy_q;
  assign o_mem_addr    = addr_q;
  assign o_mem_wdata   = wd_q;
  assign o_mem_we      = we_q;
  assign o_mem_re      = re_q;

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  sequence push_five;
    o_mem_we [*5];
  endsequence
  sequence fill_three;
    o_mem_re [*3] ##1 !o_mem_re;
  endsequence

  edge_flag_a: assert property (i_pin_cfg.en && prev_q && !s2_q && !i_src_ack[2] |=> o_flags[2])
    else $error("pin edge did not set flag");
  level_hold_a: assert property (i_pin_cfg.en && i_pin_cfg.mode && !s2_q |=> o_flags[2])
    else $error("flag dropped while pin asserted");
  pin_off_a: assert property (!i_pin_cfg.en |=> !o_flags[2])
    else $error("flag set with pin disabled");
  set_wins_a: assert property (i_src_event[12] && i_src_ack[12] |=> o_flags[12])
    else $error("event lost to clear");
  no_request_a: assert property ((flags_q & ie & irs_pkg::IMPL_MASK) == 32'h0 |=> !o_irq_request)
    else $error("request without enabled flag");
  push_seq_a: assert property (st_q == irs_pkg::ST_IDLE && start |=> ##1 push_five ##1 o_mask_set)
    else $error("entry push order broken");
  pc_pushed_a: assert property (st_q == irs_pkg::ST_IDLE && start |=> ##1 o_mem_we && o_mem_wdata == $past(i_regs.pc[7:0], 2))
    else $error("wrong program counter pushed");
  sp_final_a: assert property (st_q == irs_pkg::ST_PUSH && idx_q == irs_pkg::PUSH_LAST |=> o_sp == o_mem_addr - 16'h0001)
    else $error("stack pointer not below stored codes");
  vec_bytes_a: assert property (st_q == irs_pkg::ST_VECH |=> o_mem_re && o_mem_addr == o_vector_addr ##1 o_mem_addr == o_vector_addr + 16'h0001)
    else $error("vector byte order broken");
  pop_walk_a: assert property (st_q == irs_pkg::ST_IDLE && !start && i_return_start |=> ##1 o_mem_re [*5] ##1 (st_q == irs_pkg::ST_FILL))
    else $error("return pop sequence broken");
  fill_a: assert property (st_q == irs_pkg::ST_FILL && idx_q == 3'h0 |=> fill_three)
    else $error("pipeline fill not three bytes");

endmodule

//--- testbench/irs_mem_model.sv
// Purpose: Memory seen by the stack and vector engine
// Assumes: Read data valid in the cycle the read strobe is high
// Notes:   Unwritten bytes read as low address byte xor 5a
`timescale 1ns/1ps
module irs_mem_model (
  input  wire logic        i_mclk,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_we,
  input  wire logic        i_re,
  output logic [7:0]       o_rdata
);
  logic [7:0]  mem [logic [15:0]];
  logic [15:0] wr_a [$];
  logic [7:0]  wr_d [$];
  logic [7:0]  last_q = 8'h00;
  // ****************
  // Read and write
  // ****************
  always @* begin
    if (i_re) begin
      o_rdata = mem.exists(i_addr) ? mem[i_addr] : (i_addr[7:0] ^ 8'h5a);
    end else begin
      o_rdata = ~last_q;
    end
  end
  always @(posedge i_mclk) begin
    if (i_re) last_q <= o_rdata;
    if (i_we) begin
      mem[i_addr] = i_wdata;
      wr_a.push_back(i_addr);
      wr_d.push_back(i_wdata);
    end
  end
endmodule

//--- testbench/test_interrupt_request_and_stacking.sv
// Purpose: Self-checking bench for the request and stacking block
// Assumes: Inputs driven by non-blocking assignment at the rising edge
// Notes:   Outputs are sampled at the falling edge, or 1 ns after the rising edge in wait_done
`timescale 1ns/1ps
module test_interrupt_request_and_stacking;
  logic                   i_mclk, i_reset, i_irq_pin_n, i_stop, i_insn_done, i_return_start;
  irs_pkg::irs_pin_cfg_s  cfg;
  irs_pkg::irs_regs_s     regs, o_regs;
  logic [31:0]            ev, ie, ack, o_flags;
  logic [15:0]            i_sp, o_sp, o_vector_addr, mem_addr;
  logic [23:0]            o_queue;
  logic [7:0]             rdata, wdata;
  logic                   o_pullup_on, o_pin_level, o_stop_wake, o_irq_request;
  logic                   o_mask_set, o_done, o_busy, we, re;
  int                     n_mismatch, num_checks, cycles;
  irs_top irs_top_inst (.i_mclk(i_mclk), .i_reset(i_reset), .i_irq_pin_n(i_irq_pin_n), .i_pin_cfg(cfg),
    .i_stop(i_stop), .o_pullup_on(o_pullup_on), .o_pin_level(o_pin_level), .o_stop_wake(o_stop_wake),
    .i_src_event(ev), .i_src_ie(ie), .i_src_ack(ack), .o_flags(o_flags), .o_irq_request(o_irq_request),
    .o_vector_addr(o_vector_addr), .i_insn_done(i_insn_done), .i_return_start(i_return_start), .i_regs(regs),
    .i_sp(i_sp), .o_regs(o_regs), .o_sp(o_sp), .o_queue(o_queue), .o_mask_set(o_mask_set), .o_done(o_done),
    .o_busy(o_busy), .i_mem_rdata(rdata), .o_mem_addr(mem_addr), .o_mem_wdata(wdata), .o_mem_we(we),
    .o_mem_re(re));
  irs_mem_model irs_mem_model_inst (.i_mclk(i_mclk), .i_addr(mem_addr), .i_wdata(wdata), .i_we(we),
    .i_re(re), .o_rdata(rdata));
  // ****************
  // Clock, timeout
  // ****************
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ****************
  // Tasks
  // ****************
  task automatic cyc(int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic look;
    @(negedge i_mclk);
  endtask
  task automatic chk(string nm, logic [39:0] e, logic [39:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pulse_ack(logic [31:0] m);
    cyc(1);
    ack <= m;
    cyc(1);
    ack <= 32'h0;
    cyc(2);
    look();
  endtask
  task automatic wait_done;
    int k;
    k = 0;
    while (o_done !== 1'b1 && k < 40) begin
      @(posedge i_mclk);
      #1;
      k++;
    end
    chk("done", 1'b1, o_done);
  endtask
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [7:0] memval(logic [15:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction
  // ****************
  // Main sequence
  // ****************
  initial begin
    logic [15:0] tgt;
    logic [7:0]  fr [5];
    i_reset = 1'b1; i_irq_pin_n = 1'b1; i_stop = 1'b0; i_insn_done = 1'b0; i_return_start = 1'b0;
    cfg = '0; regs = '0; ev = '0; ie = '0; ack = '0; i_sp = 16'h0;
    n_mismatch = 0; num_checks = 0; cycles = 0;
    cyc(20);
    i_reset <= 1'b0;
    look();
    chk("pin_level", 1'b1, o_pin_level);
    chk("flags", 32'h0, o_flags);
    cyc(1);
    i_irq_pin_n <= 1'b0;
    cyc(4);
    look();
    chk("flags", 32'h0, o_flags);
    chk("pin_level", 1'b1, o_pin_level);
    cyc(1);
    i_irq_pin_n <= 1'b1;
    cfg <= '{en: 1'b1, mode: 1'b0, ie: 1'b1, pud: 1'b0};
    cyc(4);
    i_irq_pin_n <= 1'b0;
    cyc(4);
    look();
    chk("flags", 32'h4, o_flags);
    chk("irq_request", 1'b1, o_irq_request);
    chk("pin_level", 1'b0, o_pin_level);
    chk("pullup_on", 1'b1, o_pullup_on);
    pulse_ack(32'h4);
    chk("flags", 32'h0, o_flags);
    cyc(1);
    cfg <= '{en: 1'b1, mode: 1'b1, ie: 1'b0, pud: 1'b1};
    cyc(4);
    pulse_ack(32'h4);
    chk("flags", 32'h4, o_flags);
    chk("irq_request", 1'b0, o_irq_request);
    chk("pullup_on", 1'b0, o_pullup_on);
    cyc(1);
    i_stop <= 1'b1;
    look();
    chk("stop_wake", 1'b1, o_stop_wake);
    cyc(1);
    i_stop <= 1'b0;
    i_irq_pin_n <= 1'b1;
    cyc(4);
    pulse_ack(32'h4);
    chk("flags", 32'h0, o_flags);
    chk("stop_wake", 1'b0, o_stop_wake);
    $display("test pin done");
    cyc(1);
    ie <= 32'h0008_2000;
    ev <= 32'h0108_6000;
    cyc(1);
    ev <= 32'h0;
    cyc(2);
    look();
    chk("flags", 32'h0008_6000, o_flags);
    chk("irq_request", 1'b1, o_irq_request);
    cyc(1);
    ev <= 32'h2000;
    ack <= 32'h2000;
    cyc(1);
    ev <= 32'h0;
    ack <= 32'h0;
    cyc(1);
    look();
    chk("flags", 32'h0008_6000, o_flags);
    cyc(1);
    regs <= '{pc: 16'h1234, x: 8'h56, a: 8'h78, cond: 8'h60};
    i_sp <= 16'h00ff;
    i_insn_done <= 1'b1;
    cyc(2);
    i_insn_done <= 1'b0;
    look();
    chk("busy", 1'b1, o_busy);
    wait_done();
    fr = '{8'h34, 8'h12, 8'h56, 8'h78, 8'h60};
    chk("writes", 5, irs_mem_model_inst.wr_a.size());
    for (int i = 0; i < 5; i++) begin
      chk("push_addr", 16'h00ff - i, irs_mem_model_inst.wr_a[i]);
      chk("push_data", fr[i], irs_mem_model_inst.wr_d[i]);
    end
    tgt = {memval(16'hffe4), memval(16'hffe5)};
    chk("vector_addr", 16'hffe4, o_vector_addr);
    chk("sp", 16'h00fa, o_sp);
    chk("pc", tgt, o_regs.pc);
    chk("cond", 8'h68, o_regs.cond);
    chk("queue", {memval(tgt), memval(tgt + 16'h1), memval(tgt + 16'h2)}, o_queue);
    $display("test entry done");
    pulse_ack(32'hffff_ffff);
    cyc(1);
    i_sp <= 16'h00fa;
    i_return_start <= 1'b1;
    cyc(1);
    i_return_start <= 1'b0;
    wait_done();
    chk("regs", {16'h1234, 8'h56, 8'h78, 8'h60}, o_regs);
    chk("sp", 16'h00ff, o_sp);
    chk("busy", 1'b0, o_busy);
    chk("queue", {8'h6e, 8'h6f, 8'h6c}, o_queue);
    $display("test return done");
    summarize();
  end
endmodule
